// *** tcs_touch_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing figures for
 * the touch calibration, alert and sounder block.
 * Assumes a single 250 MHz clock and byte-wide registers.
 */
`ifndef TCS_TOUCH_REGS_SVH
`define TCS_TOUCH_REGS_SVH

`define TCS_OFF_EVENT_BUF 8'h00
`define TCS_OFF_FAULT 8'h01
`define TCS_OFF_TOUCH_CFG 8'h03
`define TCS_OFF_THR_FIRST 8'h04
`define TCS_OFF_THR_LAST 8'h0b
`define TCS_OFF_ALERT_CFG 8'h0f
`define TCS_OFF_CLICK_CFG 8'h10
`define TCS_OFF_HELD_KEY 8'h12
`define TCS_OFF_DESCRIPTOR 8'h14

`define TCS_BIT_AUTOCAL_ENABLE 0
`define TCS_BIT_ALERT_ENABLE 0
`define TCS_FLD_ALERT_RATE 7:4
`define TCS_BIT_CLICK_LENGTH_SEL 2
`define TCS_BIT_TONE_SELECT 1
`define TCS_BIT_SOUNDER_ON 0

`define TCS_RST_TOUCH_CFG 8'h00
`define TCS_RST_ALERT_CFG 8'h00
`define TCS_RST_CLICK_CFG 8'h00
`define TCS_RST_HELD_KEY 8'h00
`define TCS_RST_THR 8'h00
`define TCS_THR_MAX 8'h3f

`define TCS_CLK_MHZ 250
`define TCS_CLICK_SHORT_MS 10
`define TCS_TONE_LOW_HZ 1000
`define TCS_HOLDOFF_MULT 4
`define TCS_RECAL_LAST 6'h3f

// Arbitrary neutral descriptor text; length excludes the zero byte
`define TCS_DESC_TEXT "VND:NONE,PN:TK8,QUAL:REL,VER:1_0"
`define TCS_DESC_LEN 6'd32

`endif

// *** tcs_pkg.sv ***
/*
 * Types shared by the touch calibration, alert and sounder block.
 * Assumes nothing of its surroundings.
 */
package tcs_pkg;
	typedef logic [7:0] tcs_byte_type;
	typedef logic [7:0][7:0] tcs_pad_bytes_type;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tcs_acc_type;
	typedef enum {SND_IDLE, SND_CLICK} tcs_snd_state_type;
endpackage

// *** tcs_touch_calib.sv ***
/*
 * Back end of an eight-pad touch controller: thresholds, baseline capture,
 * auto-calibration, held-key recalibration, latching open-drain alert with
 * hold-off, key-click sounder and descriptor register.
 * Assumes the serial slave delivers one-cycle byte accesses on acc_i, the
 * capacitance front end pulses sample_valid_i once per detection cycle,
 * tick_i pulses once per master tick, and the alert pin has a pull-up.
 */
`timescale 1ns/1ps
`include "tcs_touch_regs.svh"

module tcs_touch_calib
	import tcs_pkg::*;
#(
	parameter int CLICK_CYC = `TCS_CLK_MHZ * 1000 * `TCS_CLICK_SHORT_MS,
	parameter int HALF_TONE_CYC = `TCS_CLK_MHZ * 1000000 /
		(2 * `TCS_TONE_LOW_HZ)
) (
	input wire logic mclk_i, // Clock
	input wire logic sys_rst_i, // Async reset, active high
	input wire tcs_acc_type acc_i, // Register access from serial slave
	output logic [7:0] rd_data_o, // Read data, one cycle after rd
	input wire logic sample_valid_i, // One detection cycle done
	input wire tcs_pad_bytes_type meas_i, // Per-pad capacitance
	input wire logic tick_i, // Master tick pulse
	input wire logic buffer_empty_flag_i, // Event buffer empty
	input wire logic [1:0] fault_code_i, // Fault code
	output logic alert_o, // Alert pin drive level, always low
	output logic alert_oe_n_o, // Alert pin enable, low drives
	output logic sounder_o, // Piezo drive
	output logic [7:0] touch_o // Per-pad touch status
);

	////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic is_touch(input logic [7:0] meas,
		input logic [7:0] base, input logic [7:0] thr);
		is_touch = (meas > base) && ((meas - base) > thr);
	endfunction

	function automatic logic [7:0] desc_char(input logic [5:0] idx);
		logic [8*32-1:0] text;
		text = `TCS_DESC_TEXT;
		if (idx >= `TCS_DESC_LEN) begin
			desc_char = 8'h00;
		end else begin
			desc_char = text[8*(6'd31 - idx) +: 8];
		end
	endfunction

	function automatic logic in_thr(input logic [7:0] addr);
		in_thr = (addr >= `TCS_OFF_THR_FIRST) && (addr <= `TCS_OFF_THR_LAST);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Host registers

	tcs_pad_bytes_type thr, next_thr;
	logic [7:0] touch_cfg, next_touch_cfg;
	logic [7:0] alert_cfg, next_alert_cfg;
	logic [7:0] click_cfg, next_click_cfg;
	logic [7:0] held_key_factor, next_held_key_factor;
	logic [5:0] desc_idx, next_desc_idx;
	logic [7:0] next_rd_data;
	logic [2:0] thr_sel;

	always_comb begin
		next_thr = thr;
		next_touch_cfg = touch_cfg;
		next_alert_cfg = alert_cfg;
		next_click_cfg = click_cfg;
		next_held_key_factor = held_key_factor;
		next_desc_idx = desc_idx;
		next_rd_data = rd_data_o;
		thr_sel = 3'(acc_i.addr - `TCS_OFF_THR_FIRST);
		if (acc_i.wr) begin
			if (in_thr(acc_i.addr)) begin
				if (acc_i.wdata > `TCS_THR_MAX) begin
					next_thr[thr_sel] = `TCS_THR_MAX;
				end else begin
					next_thr[thr_sel] = acc_i.wdata;
				end
			end else if (acc_i.addr == `TCS_OFF_TOUCH_CFG) begin
				next_touch_cfg = acc_i.wdata;
			end else if (acc_i.addr == `TCS_OFF_ALERT_CFG) begin
				next_alert_cfg = acc_i.wdata;
			end else if (acc_i.addr == `TCS_OFF_CLICK_CFG) begin
				next_click_cfg = {5'h00, acc_i.wdata[2:0]};
			end else if (acc_i.addr == `TCS_OFF_HELD_KEY) begin
				next_held_key_factor = acc_i.wdata;
			end
		end
		if (acc_i.rd) begin
			if (in_thr(acc_i.addr)) begin
				next_rd_data = thr[thr_sel];
			end else if (acc_i.addr == `TCS_OFF_TOUCH_CFG) begin
				next_rd_data = touch_cfg;
			end else if (acc_i.addr == `TCS_OFF_ALERT_CFG) begin
				next_rd_data = alert_cfg;
			end else if (acc_i.addr == `TCS_OFF_CLICK_CFG) begin
				next_rd_data = click_cfg;
			end else if (acc_i.addr == `TCS_OFF_HELD_KEY) begin
				next_rd_data = held_key_factor;
			end else if (acc_i.addr == `TCS_OFF_DESCRIPTOR) begin
				next_rd_data = desc_char(desc_idx);
			end else begin
				next_rd_data = 8'h00;
			end
		end
		// Burst reads walk the text; any other access rewinds it
		if (acc_i.rd && acc_i.addr == `TCS_OFF_DESCRIPTOR) begin
			if (desc_idx < `TCS_DESC_LEN) begin
				next_desc_idx = desc_idx + 6'd1;
			end
		end else if (acc_i.rd || acc_i.wr) begin
			next_desc_idx = 6'd0;
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			thr <= {8{`TCS_RST_THR}};
			touch_cfg <= `TCS_RST_TOUCH_CFG;
			alert_cfg <= `TCS_RST_ALERT_CFG;
			click_cfg <= `TCS_RST_CLICK_CFG;
			held_key_factor <= `TCS_RST_HELD_KEY;
			desc_idx <= 6'd0;
			rd_data_o <= 8'h00;
		end else begin
			thr <= next_thr;
			touch_cfg <= next_touch_cfg;
			alert_cfg <= next_alert_cfg;
			click_cfg <= next_click_cfg;
			held_key_factor <= next_held_key_factor;
			desc_idx <= next_desc_idx;
			rd_data_o <= next_rd_data;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Baseline and touch detection

	tcs_pad_bytes_type base, next_base;
	logic base_valid, next_base_valid;
	logic [5:0] samp_cnt, next_samp_cnt;
	logic [14:0] stuck_cnt [8];
	logic [14:0] next_stuck_cnt [8];
	logic [7:0] next_touch;
	logic [14:0] stuck_limit;

	always_comb begin
		next_base = base;
		next_base_valid = base_valid;
		next_samp_cnt = samp_cnt;
		next_stuck_cnt = stuck_cnt;
		next_touch = touch_o;
		// Nine bits so that code 0xff gives a factor of 256, not zero
		stuck_limit = {9'(held_key_factor) + 9'd1, 6'h00};
		if (sample_valid_i) begin
			if (!base_valid) begin
				next_base = meas_i;
				next_base_valid = 1'b1;
				next_touch = 8'h00;
			end else begin
				next_samp_cnt = samp_cnt + 6'd1;
				for (int p = 0; p < 8; p++) begin
					next_touch[p] = is_touch(meas_i[p], base[p], thr[p]);
					if (!next_touch[p]) begin
						next_stuck_cnt[p] = 15'd0;
					end else if (held_key_factor == 8'h00) begin
						next_stuck_cnt[p] = 15'd0;
					end else if (stuck_cnt[p] + 15'd1 >= stuck_limit) begin
						next_base[p] = meas_i[p];
						next_stuck_cnt[p] = 15'd0;
						next_touch[p] = 1'b0;
					end else begin
						next_stuck_cnt[p] = stuck_cnt[p] + 15'd1;
					end
				end
				if (samp_cnt == `TCS_RECAL_LAST &&
					touch_cfg[`TCS_BIT_AUTOCAL_ENABLE] &&
					next_touch == 8'h00) begin
					next_base = meas_i;
				end
			end
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			base <= '0;
			base_valid <= 1'b0;
			samp_cnt <= 6'd0;
			touch_o <= 8'h00;
			for (int p = 0; p < 8; p++) begin
				stuck_cnt[p] <= 15'd0;
			end
		end else begin
			base <= next_base;
			base_valid <= next_base_valid;
			samp_cnt <= next_samp_cnt;
			touch_o <= next_touch;
			stuck_cnt <= next_stuck_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Alert latch with hold-off

	logic prev_empty, next_prev_empty;
	logic [1:0] prev_fault, next_prev_fault;
	logic pend_buf, next_pend_buf, pend_fault, next_pend_fault;
	logic src_buf, next_src_buf, src_fault, next_src_fault;
	logic [5:0] hold_cnt, next_hold_cnt;
	logic alert_en, buf_evt, fault_evt, hold_done;

	always_comb begin
		alert_en = alert_cfg[`TCS_BIT_ALERT_ENABLE];
		buf_evt = alert_en && prev_empty && !buffer_empty_flag_i;
		fault_evt = alert_en && prev_fault == 2'b00 &&
			fault_code_i != 2'b00;
		hold_done = hold_cnt >= 6'(alert_cfg[`TCS_FLD_ALERT_RATE] *
			`TCS_HOLDOFF_MULT);
		next_prev_empty = buffer_empty_flag_i;
		next_prev_fault = fault_code_i;
		next_pend_buf = (pend_buf || buf_evt) && alert_en;
		next_pend_fault = (pend_fault || fault_evt) && alert_en;
		next_src_buf = src_buf;
		next_src_fault = src_fault;
		next_hold_cnt = hold_cnt;
		if (tick_i && hold_cnt != 6'h3f) begin
			next_hold_cnt = hold_cnt + 6'd1;
		end
		if ((acc_i.rd || acc_i.wr) && acc_i.addr == `TCS_OFF_EVENT_BUF) begin
			next_src_buf = 1'b0;
		end
		if (acc_i.wr && acc_i.addr == `TCS_OFF_FAULT) begin
			next_src_fault = 1'b0;
		end
		// Latch comes after the clears so a coinciding event wins
		if ((next_pend_buf || next_pend_fault) && hold_done) begin
			next_src_buf = next_src_buf || next_pend_buf;
			next_src_fault = next_src_fault || next_pend_fault;
			next_pend_buf = 1'b0;
			next_pend_fault = 1'b0;
			next_hold_cnt = 6'd0;
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prev_empty <= 1'b1;
			prev_fault <= 2'b00;
			pend_buf <= 1'b0;
			pend_fault <= 1'b0;
			src_buf <= 1'b0;
			src_fault <= 1'b0;
			hold_cnt <= 6'h3f;
			alert_o <= 1'b0;
			alert_oe_n_o <= 1'b1;
		end else begin
			prev_empty <= next_prev_empty;
			prev_fault <= next_prev_fault;
			pend_buf <= next_pend_buf;
			pend_fault <= next_pend_fault;
			src_buf <= next_src_buf;
			src_fault <= next_src_fault;
			hold_cnt <= next_hold_cnt;
			alert_o <= 1'b0;
			alert_oe_n_o <= !(next_src_buf || next_src_fault);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Key-click sounder

	tcs_snd_state_type snd_state, next_snd_state;
	logic [23:0] len_cnt, next_len_cnt;
	logic [16:0] tone_cnt, next_tone_cnt, tone_reload;
	logic next_sounder;

	always_comb begin
		next_snd_state = snd_state;
		next_len_cnt = len_cnt;
		next_tone_cnt = tone_cnt;
		next_sounder = sounder_o;
		if (click_cfg[`TCS_BIT_TONE_SELECT]) begin
			tone_reload = 17'(HALF_TONE_CYC / 2 - 1);
		end else begin
			tone_reload = 17'(HALF_TONE_CYC - 1);
		end
		case (snd_state)
			SND_IDLE: begin
				next_sounder = 1'b0;
				if (click_cfg[`TCS_BIT_SOUNDER_ON] &&
					(next_touch & ~touch_o) != 8'h00) begin
					next_snd_state = SND_CLICK;
					next_tone_cnt = tone_reload;
					next_sounder = 1'b1;
					if (click_cfg[`TCS_BIT_CLICK_LENGTH_SEL]) begin
						next_len_cnt = 24'(2 * CLICK_CYC - 1);
					end else begin
						next_len_cnt = 24'(CLICK_CYC - 1);
					end
				end
			end
			SND_CLICK: begin
				if (!click_cfg[`TCS_BIT_SOUNDER_ON] || len_cnt == 24'd0) begin
					next_snd_state = SND_IDLE;
					next_sounder = 1'b0;
				end else begin
					next_len_cnt = len_cnt - 24'd1;
					if (tone_cnt == 17'd0) begin
						next_tone_cnt = tone_reload;
						next_sounder = !sounder_o;
					end else begin
						next_tone_cnt = tone_cnt - 17'd1;
					end
				end
			end
			default: begin
				next_snd_state = SND_IDLE;
				next_sounder = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			snd_state <= SND_IDLE;
			len_cnt <= 24'd0;
			tone_cnt <= 17'd0;
			sounder_o <= 1'b0;
		end else begin
			snd_state <= next_snd_state;
			len_cnt <= next_len_cnt;
			tone_cnt <= next_tone_cnt;
			sounder_o <= next_sounder;
		end
	end

endmodule

// *** tcs_touch_calib_properties.sv ***
/*
 * Port checker for the touch calibration, alert and sounder block.
 * Assumes it is bound into every tcs_touch_calib instance.
 */
`timescale 1ns/1ps
module tcs_touch_calib_properties
	import tcs_pkg::*;
#(
	parameter int CLICK_CYC = 40,
	parameter int HALF_TONE_CYC = 4
) (
	input wire logic mclk_i, // Clock
	input wire logic sys_rst_i, // Async reset
	input wire tcs_acc_type acc_i, // Register access
	input wire logic [7:0] rd_data_o, // Read data
	input wire logic sample_valid_i, // Detection cycle done
	input wire tcs_pad_bytes_type meas_i, // Pad capacitance
	input wire logic tick_i, // Master tick
	input wire logic buffer_empty_flag_i, // Buffer empty
	input wire logic [1:0] fault_code_i, // Fault code
	input wire logic alert_o, // Alert drive level
	input wire logic alert_oe_n_o, // Alert enable, low drives
	input wire logic sounder_o, // Piezo drive
	input wire logic [7:0] touch_o // Touch status
);
default clocking @(posedge mclk_i); endclocking
default disable iff (sys_rst_i);
// Mirrors of written configuration and a run length of sounder silence
logic [7:0] alert_cfg;
logic snd_en;
tcs_acc_type acc_q;
int low_run;
always_ff @(posedge mclk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		alert_cfg <= 8'h00;
		snd_en <= 1'b0;
		acc_q <= '0;
		low_run <= 0;
	end else begin
		acc_q <= acc_i;
		if (acc_i.wr && acc_i.addr == 8'h0f)
			alert_cfg <= acc_i.wdata;
		if (acc_i.wr && acc_i.addr == 8'h10)
			snd_en <= acc_i.wdata[0];
		if (sounder_o)
			low_run <= 0;
		else if (low_run < 1000)
			low_run <= low_run + 1;
	end
end
////////////////////////////////////////////////////////////////////////////
drive_low_a: assert property (alert_o == 1'b0)
	else $error("alert pin drive level not low");
thr_clamp_a: assert property (acc_i.wr && acc_i.addr == 8'h04 &&
	acc_i.wdata > 8'h3f ##1 !acc_i.wr ##1 acc_i.rd && acc_i.addr == 8'h04
	|=> rd_data_o == 8'h3f)
	else $error("threshold not clamped");
desc_rewind_a: assert property ((acc_i.wr || acc_i.rd) &&
	acc_i.addr != 8'h14 ##1 !acc_i.rd && !acc_i.wr ##1
	acc_i.rd && acc_i.addr == 8'h14 |=> rd_data_o == 8'h56)
	else $error("descriptor did not restart");
alert_release_a: assert property ($rose(alert_oe_n_o) |->
	acc_q.addr == 8'h00 && (acc_q.rd || acc_q.wr) ||
	acc_q.addr == 8'h01 && acc_q.wr)
	else $error("alert released without a clearing access");
alert_gate_a: assert property ($fell(alert_oe_n_o) |->
	$past(alert_cfg[0]))
	else $error("alert latched while disabled");
alert_fast_a: assert property (($fell(buffer_empty_flag_i) ||
	fault_code_i != 2'b00 && $past(fault_code_i) == 2'b00) &&
	alert_cfg[0] && alert_cfg[7:4] == 4'h0 |=> !alert_oe_n_o)
	else $error("alert not latched at once");
touch_hold_a: assert property (!sample_valid_i |=> $stable(touch_o))
	else $error("touch status moved without a sample");
click_start_a: assert property ($rose(sounder_o) &&
	low_run > 2 * HALF_TONE_CYC |-> (touch_o & ~$past(touch_o)) != 8'h00)
	else $error("click started without a new touch");
tone_half_a: assert property ($rose(sounder_o) |-> sounder_o[*2])
	else $error("tone half period too short");
snd_off_a: assert property (!snd_en [*2] |=> !sounder_o)
	else $error("sounder active while disabled");
endmodule
bind tcs_touch_calib tcs_touch_calib_properties #(
	.CLICK_CYC(CLICK_CYC),
	.HALF_TONE_CYC(HALF_TONE_CYC)
) tcs_touch_calib_properties_i (.mclk_i, .sys_rst_i, .acc_i, .rd_data_o,
	.sample_valid_i, .meas_i, .tick_i, .buffer_empty_flag_i, .fault_code_i,
	.alert_o, .alert_oe_n_o, .sounder_o, .touch_o);

// *** tcs_host_pull.sv ***
/*
 * Host side of the open-drain alert line: the external pull-up.
 * Assumes the block pulls the line only while alert_oe_n_o is low.
 */
`timescale 1ns/1ps
module tcs_host_pull
	import tcs_pkg::*;
(
	input wire logic alert_o, // Block drive level
	input wire logic alert_oe_n_o, // Block enable, low drives
	output logic irq_n_o // Resolved line, active low
);
// Pull-up holds the line high whenever the block lets go
assign irq_n_o = alert_oe_n_o ? 1'b1 : alert_o;
endmodule

// *** test_touch_calib_alert_sounder.sv ***
/*
 * Self-checking bench for the touch calibration, alert and sounder block.
 * Assumes short click and tone counts so that a click lasts tens of cycles.
 */
`timescale 1ns/1ps
`include "tcs_touch_regs.svh"
`define CHK(n, e, g) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("mismatch %s exp %h got %h", n, e, g); \
	end \
end
module test_touch_calib_alert_sounder
	import tcs_pkg::*;
;
localparam int HALF = 4;
localparam int CLICK = 40;
logic mclk_i = 1'b0;
logic sys_rst_i = 1'b1;
logic sample_valid_i = 1'b0;
logic tick_i = 1'b0;
logic buffer_empty_flag_i = 1'b1;
logic [1:0] fault_code_i = 2'b00;
tcs_acc_type acc_i = '0;
tcs_pad_bytes_type meas_i = '0;
logic [7:0] rd_data_o, touch_o, d;
logic alert_o, alert_oe_n_o, sounder_o, irq_n;
int n_fail = 0;
int comparisons = 0;
tcs_touch_calib #(.CLICK_CYC(CLICK), .HALF_TONE_CYC(HALF)) tcs_touch_calib_i (
	.mclk_i, .sys_rst_i, .acc_i, .rd_data_o, .sample_valid_i, .meas_i,
	.tick_i, .buffer_empty_flag_i, .fault_code_i, .alert_o, .alert_oe_n_o,
	.sounder_o, .touch_o);
tcs_host_pull tcs_host_pull_i (.alert_o, .alert_oe_n_o, .irq_n_o(irq_n));
initial begin
	forever #2 mclk_i = ~mclk_i;
end
task automatic step(int n = 1);
	repeat (n) @(posedge mclk_i);
	#1;
endtask
task automatic do_reset;
	sys_rst_i = 1'b1;
	step(3);
	sys_rst_i = 1'b0;
endtask
task automatic acc(logic [7:0] a, logic [7:0] w, logic wr);
	acc_i = '{a, w, wr, !wr};
	step();
	d = rd_data_o;
	acc_i = '0;
	step();
endtask
task automatic wr_rd(logic [7:0] a, logic [7:0] w, logic [7:0] e);
	acc(a, w, 1'b1);
	acc(a, 8'h00, 1'b0);
	`CHK("reg", e, d)
endtask
task automatic smp(logic [7:0] p0, int n = 1);
	repeat (n) begin
		meas_i = {{7{8'h10}}, p0};
		sample_valid_i = 1'b1;
		step();
		sample_valid_i = 1'b0;
		step();
	end
endtask
task automatic tick(int n);
	repeat (n) begin
		tick_i = 1'b1;
		step();
		tick_i = 1'b0;
		step();
	end
endtask
task automatic t_touch;
	do_reset();
	acc(8'h04, 8'h05, 1'b1);
	smp(8'h20);
	`CHK("touch", 8'h00, touch_o)
	smp(8'h26);
	`CHK("touch", 8'h01, touch_o)
	smp(8'h25);
	`CHK("touch", 8'h00, touch_o)
	smp(8'h30, 130);
	`CHK("touch", 8'h01, touch_o)
	smp(8'h20);
	acc(8'h12, 8'h01, 1'b1);
	smp(8'h30, 127);
	`CHK("touch", 8'h01, touch_o)
	smp(8'h30, 2);
	`CHK("touch", 8'h00, touch_o)
endtask
task automatic t_cal;
	do_reset();
	acc(8'h04, 8'h05, 1'b1);
	smp(8'h10);
	smp(8'h14, 64);
	smp(8'h19);
	`CHK("autocal", 8'h01, touch_o)
	acc(8'h03, 8'h01, 1'b1);
	smp(8'h14, 64);
	smp(8'h19);
	`CHK("autocal", 8'h00, touch_o)
	smp(8'h30, 64);
	`CHK("autocal", 8'h01, touch_o)
endtask
task automatic t_alert;
	do_reset();
	acc(8'h0f, 8'h01, 1'b1);
	buffer_empty_flag_i = 1'b0;
	step();
	`CHK("irq", 1'b0, irq_n)
	acc(8'h00, 8'h00, 1'b0);
	`CHK("irq", 1'b1, irq_n)
	buffer_empty_flag_i = 1'b1;
	fault_code_i = 2'b01;
	step();
	`CHK("irq", 1'b0, irq_n)
	acc(8'h01, 8'h00, 1'b0);
	`CHK("irq", 1'b0, irq_n)
	acc(8'h01, 8'h00, 1'b1);
	`CHK("irq", 1'b1, irq_n)
	fault_code_i = 2'b00;
	acc(8'h0f, 8'h00, 1'b1);
	buffer_empty_flag_i = 1'b0;
	step(2);
	`CHK("irq", 1'b1, irq_n)
	buffer_empty_flag_i = 1'b1;
	acc(8'h0f, 8'h11, 1'b1);
	buffer_empty_flag_i = 1'b0;
	step();
	`CHK("irq", 1'b1, irq_n)
	tick(3);
	`CHK("irq", 1'b1, irq_n)
	tick(1);
	`CHK("irq", 1'b0, irq_n)
	acc(8'h00, 8'h00, 1'b1);
	buffer_empty_flag_i = 1'b1;
	tick(4);
	buffer_empty_flag_i = 1'b0;
	step();
	`CHK("irq", 1'b0, irq_n)
endtask
task automatic t_snd(logic [7:0] cfg);
	int hi, fl, half, len, e, f;
	logic p;
	half = cfg[1] ? HALF / 2 : HALF;
	len = cfg[2] ? 2 * CLICK : CLICK;
	e = cfg[0] ? len / 2 : 0;
	f = cfg[0] ? len / (2 * half) : 0;
	hi = 0;
	fl = 0;
	do_reset();
	acc(8'h10, cfg, 1'b1);
	acc(8'h04, 8'h05, 1'b1);
	smp(8'h10);
	smp(8'h20);
	for (int i = 0; i < 100; i++) begin
		p = sounder_o;
		step();
		hi += sounder_o;
		fl += p & !sounder_o;
	end
	`CHK("snd_hi", 1'b1, hi + 3 >= e && hi <= e + 1)
	`CHK("snd_tone", 1'b1, fl + 1 >= f && fl <= f + 1)
endtask
task automatic report_and_stop;
	$display("comparisons %0d n_fail %0d", comparisons, n_fail);
	if (n_fail == 0 && comparisons > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
	string s;
	do_reset();
	wr_rd(8'h04, 8'h50, 8'h3f);
	wr_rd(8'h0b, 8'h2a, 8'h2a);
	wr_rd(8'h12, 8'ha5, 8'ha5);
	wr_rd(8'h10, 8'hff, 8'h07);
	wr_rd(8'h02, 8'h33, 8'h00);
	s = `TCS_DESC_TEXT;
	for (int i = 0; i <= s.len(); i++) begin
		acc(8'h14, 8'h00, 1'b0);
		`CHK("desc", i < s.len() ? 8'(s[i]) : 8'h00, d)
	end
	t_touch();
	t_cal();
	t_alert();
	for (int k = 0; k < 5; k++)
		t_snd(k == 4 ? 8'h00 : 8'(2 * k + 1));
	report_and_stop();
end
initial begin
	step(20000);
	n_fail++;
	report_and_stop();
end
endmodule
